/* File: rtl/cmpc_top.sv */
// Comparator control: registers, output conditioning and event flag.
// Assumes an AXI4-Lite master on aclk and an asynchronous comparator
// output; the analog parts sit outside and take the control outputs.
`timescale 1ns/1ps
module cmpc_top import cmpc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Comparator and interrupt controller
  input wire logic cmp_analog_out,
  input wire logic isr_enter,
  input wire logic [7:0] other_flag_set,
  output logic cmp_irq,
  // Comparator and DAC controls
  output logic cmp_powerdown,
  output logic dac_powerdown,
  output logic dac_ref_bandgap,
  output logic [6:0] dac_level_code,
  output logic [1:0] bandgap_level_select,
  output logic dac_buffer_select,
  output logic neg_uses_dac,
  output logic [3:0] neg_pin_connect,
  output logic pos_uses_amp,
  output logic [3:0] pos_pin_connect,
  // Amplifier controls
  output logic amp_powerdown,
  output logic [1:0] amp_gain_select,
  output logic [1:0] amp_mode_select,
  output logic [1:0] amp_positive_source_select,
  output logic amp_negative_level_select,
  // Pin routing
  output logic p21_out,
  output logic p21_oe_n,
  output logic p34_amp_route,
  output logic p20_dac_route
);

  logic [7:0] dac_route_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] dac_ctl_q;
  logic [7:0] cmp_ctl_q;
  logic [7:0] input_sel_q;
  logic [7:0] amp_ctl_q;
  logic [7:0] enables_q;
  logic [7:0] bg_sel_q;

  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_commit;
  logic wr_hit;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;

  logic cmp_sync;
  logic raw_result;
  logic deb_out;
  logic cond_out;
  logic cond_prev_q;
  logic trig_hit;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  cmpc_trig_e trig_sel;

  // Address check: aligned, in range and a known register
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    addr_ok = (a[IDX_LSB-1:0] == '0) && (a[ADDR_W-1:IDX_MSB+1] == '0)
      && (idx == IDX_DAC_ROUTE || idx == IDX_FLAGS
      || idx == IDX_DAC_CTL || idx == IDX_CMP_CTL
      || idx == IDX_INPUT_SEL || idx == IDX_AMP_CTL
      || idx == IDX_ENABLES || idx == IDX_BG_SEL);
  endfunction

  // code 1xx leaves the input open
  function automatic logic [3:0] pin_onehot(input logic [2:0] s);
    logic [3:0] one;
    one = 4'h1;
    pin_onehot = s[PIN_NC_BIT] ? 4'h0 : (one << s[PIN_NC_BIT-1:0]);
  endfunction

  // Write channel: address and data may arrive in either order
  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign wr_commit = aw_held_q && w_held_q && !bvalid;
  assign wr_idx = awaddr_q[IDX_MSB:IDX_LSB];
  assign wr_hit = wr_commit && addr_ok(awaddr_q) && wlane_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_commit) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answered next clock
  assign arready = !rvalid;
  assign rd_idx = araddr[IDX_MSB:IDX_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata <= 32'h0000_0000;
      if (addr_ok(araddr)) begin
        unique case (rd_idx)
          IDX_DAC_ROUTE: rdata[7:0] <= dac_route_q;
          IDX_FLAGS: rdata[7:0] <= flags_q;
          IDX_DAC_CTL: rdata[7:0] <= dac_ctl_q;
          // live raw result in its status bit
          IDX_CMP_CTL: begin
            rdata[7:0] <= cmp_ctl_q;
            rdata[CC_RAW] <= raw_result;
          end
          IDX_INPUT_SEL: rdata[7:0] <= input_sel_q;
          IDX_AMP_CTL: rdata[7:0] <= amp_ctl_q;
          IDX_ENABLES: rdata[7:0] <= enables_q;
          default: rdata[7:0] <= bg_sel_q;
        endcase
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Configuration registers; writes need byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_route_q <= RST_DAC_ROUTE;
      dac_ctl_q <= RST_DAC_CTL;
      cmp_ctl_q <= RST_CMP_CTL;
      input_sel_q <= RST_INPUT_SEL;
      amp_ctl_q <= RST_AMP_CTL;
      enables_q <= RST_ENABLES;
      bg_sel_q <= RST_BG_SEL;
    end else if (wr_hit) begin
      unique case (wr_idx)
        IDX_DAC_ROUTE: dac_route_q <= wbyte_q & MASK_DAC_ROUTE;
        IDX_DAC_CTL: dac_ctl_q <= wbyte_q;
        IDX_CMP_CTL: cmp_ctl_q <= wbyte_q;
        IDX_INPUT_SEL: input_sel_q <= wbyte_q;
        IDX_AMP_CTL: amp_ctl_q <= wbyte_q;
        IDX_ENABLES: enables_q <= wbyte_q;
        IDX_BG_SEL: bg_sel_q <= wbyte_q;
        default: ;
      endcase
    end
  end

  // Comparator output comes from the analog domain
  cmpc_sync #(
    .W(1)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(cmp_analog_out),
    .sync_out(cmp_sync)
  );

  assign raw_result = cmp_ctl_q[CC_PD] | cmp_sync;

  cmpc_debounce u_deb (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(raw_result),
    .settle(cmp_ctl_q[CC_DEB_HI:0]),
    .out_q(deb_out)
  );

  assign cond_out = deb_out ^ cmp_ctl_q[CC_INV];
  assign trig_sel = cmpc_trig_e'(cmp_ctl_q[CC_TRIG_HI:CC_TRIG_LO]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_prev_q <= DEB_RESET;
    end else begin
      cond_prev_q <= cond_out;
    end
  end

  always_comb begin
    unique case (trig_sel)
      TRIG_RISE: trig_hit = cond_out && !cond_prev_q;
      TRIG_FALL: trig_hit = !cond_out && cond_prev_q;
      TRIG_BOTH: trig_hit = cond_out != cond_prev_q;
      TRIG_HIGH: trig_hit = cond_out;
    endcase
  end

  // set regardless of powerdown; set wins over clear
  // writes clear where a 0 is written, so BFh hits one flag
  always_comb begin
    flag_set = other_flag_set;
    flag_set[FL_CMP] = trig_hit;
    flag_clr = 8'h00;
    if (wr_hit && wr_idx == IDX_FLAGS) begin
      flag_clr = ~wbyte_q;
    end
    if (isr_enter) begin
      flag_clr[FL_CMP] = 1'b1;
    end
    flags_d = ((flags_q & ~flag_clr) | flag_set) & MASK_FLAGS;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign cmp_irq = flags_q[FL_CMP] & enables_q[EN_CMP];

  // conditioned output to P2.1, enable low while driving
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p21_out <= DEB_RESET;
    end else begin
      p21_out <= cond_out;
    end
  end
  assign p21_oe_n = !cmp_ctl_q[CC_OE];

  assign cmp_powerdown = cmp_ctl_q[CC_PD];
  assign dac_powerdown = cmp_ctl_q[CC_PD] | dac_route_q[RT_DAC_PD];
  // reference and level; reserved codes passed as written
  assign dac_ref_bandgap = dac_ctl_q[DC_REF];
  assign dac_level_code = dac_ctl_q[DC_LVL_HI:0];
  assign bandgap_level_select = bg_sel_q[CH_BG_HI:0];
  assign dac_buffer_select = dac_route_q[RT_DAC_BUF];
  assign neg_uses_dac = input_sel_q[IS_NEG_SRC];
  assign pos_uses_amp = !input_sel_q[IS_POS_SRC];
  assign neg_pin_connect = input_sel_q[IS_NEG_SRC] ? 4'h0
    : pin_onehot(input_sel_q[IS_NEG_HI:IS_NEG_LO]);
  assign pos_pin_connect = input_sel_q[IS_POS_SRC]
    ? pin_onehot(input_sel_q[IS_POS_HI:0]) : 4'h0;
  assign amp_powerdown = amp_ctl_q[AC_PD];
  assign amp_gain_select = amp_ctl_q[AC_GAIN_HI:AC_GAIN_LO];
  assign amp_mode_select = amp_ctl_q[AC_MODE_HI:0];
  assign amp_positive_source_select = amp_ctl_q[AC_PP_HI:AC_PP_LO];
  assign amp_negative_level_select = amp_ctl_q[AC_NL];
  assign p34_amp_route = dac_route_q[RT_AMP_PIN];
  assign p20_dac_route = dac_route_q[RT_DAC_PIN];

  a_flag_on_rise: assert property (
    @(posedge aclk) disable iff (!aresetn)
    trig_sel == TRIG_RISE && $rose(cond_out) |=> flags_q[FL_CMP])
    else $error("rising edge did not set the event flag");

  a_flag_on_fall: assert property (
    @(posedge aclk) disable iff (!aresetn)
    trig_sel == TRIG_FALL && $fell(cond_out) |=> flags_q[FL_CMP])
    else $error("falling edge did not set the event flag");

  a_no_rise_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    trig_sel == TRIG_RISE && $stable(cond_out) && !flags_q[FL_CMP]
    && !other_flag_set[FL_CMP] |=> !flags_q[FL_CMP])
    else $error("flag set without a rising edge");

  a_level_holds_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    trig_sel == TRIG_HIGH && cond_out && isr_enter |=> flags_q[FL_CMP])
    else $error("high level did not keep the flag set over a clear");

  a_isr_clears: assert property (
    @(posedge aclk) disable iff (!aresetn)
    isr_enter && !trig_hit && !other_flag_set[FL_CMP]
    |=> !flags_q[FL_CMP])
    else $error("service entry did not clear the event flag");

  a_sw_clear_one: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_hit && wr_idx == IDX_FLAGS && wbyte_q == 8'hbf && !trig_hit
    && !other_flag_set[FL_CMP]
    |=> !flags_q[FL_CMP] && (flags_q & 8'hbf) == (($past(flags_q) & 8'hbf
        | $past(other_flag_set)) & 8'hb7))
    else $error("flag clear write disturbed the other flags");

  a_irq_gated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !enables_q[EN_CMP] |-> !cmp_irq)
    else $error("request raised while disabled");

  a_pd_raw_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmp_ctl_q[CC_PD] && arvalid && arready && araddr == {
      2'h0, IDX_CMP_CTL, 2'h0} |=> rvalid && rdata[CC_RAW])
    else $error("raw bit not high during powerdown");

  a_pin_follows: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !p21_oe_n ##1 !p21_oe_n |-> p21_out == $past(deb_out)
      ^ $past(cmp_ctl_q[CC_INV]))
    else $error("pin does not carry the conditioned output");

  a_write_answer: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_commit |=> bvalid)
    else $error("write response missing one clock after commit");
endmodule

/* File: rtl/cmpc_pkg.sv */
// Constants for the comparator output conditioning block.
// Assumes a single 10 MHz clock domain and an AXI4-Lite master.
package cmpc_pkg;

  // Bus geometry: byte address = 4 * register index
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices
  localparam logic [7:0] IDX_DAC_ROUTE = 8'h86;
  localparam logic [7:0] IDX_FLAGS = 8'h95;
  localparam logic [7:0] IDX_DAC_CTL = 8'h9c;
  localparam logic [7:0] IDX_CMP_CTL = 8'h9d;
  localparam logic [7:0] IDX_INPUT_SEL = 8'h9e;
  localparam logic [7:0] IDX_AMP_CTL = 8'h9f;
  localparam logic [7:0] IDX_ENABLES = 8'ha9;
  localparam logic [7:0] IDX_BG_SEL = 8'hae;

  // Reset values and implemented-bit masks
  localparam logic [7:0] RST_DAC_ROUTE = 8'h01;
  localparam logic [7:0] MASK_DAC_ROUTE = 8'h0f;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] MASK_FLAGS = 8'hf7;
  localparam logic [7:0] RST_DAC_CTL = 8'h00;
  localparam logic [7:0] RST_CMP_CTL = 8'hc0;
  localparam logic [7:0] RST_INPUT_SEL = 8'hf7;
  localparam logic [7:0] RST_AMP_CTL = 8'hec;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_BG_SEL = 8'hf8;

  // Field positions
  localparam int RT_AMP_PIN = 3;
  localparam int RT_DAC_PIN = 2;
  localparam int RT_DAC_BUF = 1;
  localparam int RT_DAC_PD = 0;
  localparam int FL_CMP = 6;
  localparam int EN_CMP = 6;
  localparam int DC_REF = 7;
  localparam int DC_LVL_HI = 6;
  localparam int CC_PD = 7;
  localparam int CC_RAW = 6;
  localparam int CC_OE = 5;
  localparam int CC_INV = 4;
  localparam int CC_TRIG_HI = 3;
  localparam int CC_TRIG_LO = 2;
  localparam int CC_DEB_HI = 1;
  localparam int IS_NEG_SRC = 7;
  localparam int IS_NEG_HI = 6;
  localparam int IS_NEG_LO = 4;
  localparam int IS_POS_SRC = 3;
  localparam int IS_POS_HI = 2;
  localparam int AC_PD = 7;
  localparam int AC_PP_HI = 6;
  localparam int AC_PP_LO = 5;
  localparam int AC_NL = 4;
  localparam int AC_GAIN_HI = 3;
  localparam int AC_GAIN_LO = 2;
  localparam int AC_MODE_HI = 1;
  localparam int CH_BG_HI = 1;
  localparam int PIN_NC_BIT = 2;

  // Flag trigger modes
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_BOTH = 2'h2,
    TRIG_HIGH = 2'h3
  } cmpc_trig_e;

  // Settle time codes and their clock counts
  localparam logic [1:0] SETTLE_NONE = 2'h0;
  localparam logic [1:0] SETTLE_4 = 2'h1;
  localparam logic [1:0] SETTLE_8 = 2'h2;
  localparam int DEB_CNT_W = 5;
  localparam logic [4:0] DEB_NONE_CYC = 5'h01;
  localparam logic [4:0] DEB_4_CYC = 5'h04;
  localparam logic [4:0] DEB_8_CYC = 5'h08;
  localparam logic [4:0] DEB_16_CYC = 5'h10;
  localparam logic DEB_RESET = 1'b1;

endpackage

/* File: rtl/cmpc_sync.sv */
// Two-flop synchroniser for levels arriving from outside the clock.
// Assumes the input is a slowly changing level.
`timescale 1ns/1ps
module cmpc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Level in and out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: rtl/cmpc_debounce.sv */
// Settle filter for the raw comparator result.
// Assumes raw is already synchronous to aclk.
`timescale 1ns/1ps
module cmpc_debounce import cmpc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filter input and setting
  input wire logic raw,
  input wire logic [1:0] settle,
  // Filtered result
  output logic out_q
);
  logic [DEB_CNT_W-1:0] cnt_q;
  logic [DEB_CNT_W-1:0] need;
  logic [DEB_CNT_W-1:0] cnt_nx;

  always_comb begin
    unique case (settle)
      SETTLE_NONE: need = DEB_NONE_CYC;
      SETTLE_4: need = DEB_4_CYC;
      SETTLE_8: need = DEB_8_CYC;
      default: need = DEB_16_CYC;
    endcase
  end

  assign cnt_nx = cnt_q + DEB_CNT_W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      out_q <= DEB_RESET;
    end else if (raw == out_q) begin
      cnt_q <= '0;
    end else if (cnt_nx >= need) begin
      cnt_q <= '0;
      out_q <= raw;
    end else begin
      cnt_q <= cnt_nx;
    end
  end

  a_deb_four_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $changed(out_q) && settle == SETTLE_4 && $past(settle, 4) == SETTLE_4
    |-> $past(raw, 1) == out_q && $past(raw, 4) == out_q
        && $past(out_q, 4) != out_q)
    else $error("debounce output changed before four settled clocks");

  a_deb_none_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    settle == SETTLE_NONE && $past(settle) == SETTLE_NONE ##0 $changed(raw)
    |=> out_q == $past(raw))
    else $error("undebounced output did not follow raw in one clock");
endmodule

/* File: bench/test_comparator_output_conditioning.sv */
// Self-checking bench for the comparator control block.
// Assumes cmpc_top on a 10 MHz aclk, driven over AXI4-Lite.
`timescale 1ns/1ps
module test_comparator_output_conditioning import cmpc_pkg::*; ;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cmp_irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, neg_pin_connect, pos_pin_connect;
  logic [1:0] bresp, rresp, bandgap_level_select, amp_gain_select;
  logic [1:0] amp_mode_select, amp_positive_source_select;
  logic cmp_analog_out, isr_enter, cmp_powerdown, dac_powerdown;
  logic [7:0] other_flag_set;
  logic [6:0] dac_level_code;
  logic dac_ref_bandgap, dac_buffer_select, neg_uses_dac, pos_uses_amp;
  logic amp_powerdown, amp_negative_level_select, p21_out, p21_oe_n;
  logic p34_amp_route, p20_dac_route;
  int miscompares, checked, cycles;

  cmpc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cmp_analog_out(cmp_analog_out), .isr_enter(isr_enter),
    .other_flag_set(other_flag_set), .cmp_irq(cmp_irq),
    .cmp_powerdown(cmp_powerdown), .dac_powerdown(dac_powerdown),
    .dac_ref_bandgap(dac_ref_bandgap), .dac_level_code(dac_level_code),
    .bandgap_level_select(bandgap_level_select),
    .dac_buffer_select(dac_buffer_select), .neg_uses_dac(neg_uses_dac),
    .neg_pin_connect(neg_pin_connect), .pos_uses_amp(pos_uses_amp),
    .pos_pin_connect(pos_pin_connect), .amp_powerdown(amp_powerdown),
    .amp_gain_select(amp_gain_select), .amp_mode_select(amp_mode_select),
    .amp_positive_source_select(amp_positive_source_select),
    .amp_negative_level_select(amp_negative_level_select),
    .p21_out(p21_out), .p21_oe_n(p21_oe_n),
    .p34_amp_route(p34_amp_route), .p20_dac_route(p20_dac_route));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d,
                           input logic [1:0] er);
    logic a, w, ta, tw;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    // Stable from negedge to the taking edge, so sample there
    while (a || w) begin
      @(negedge aclk);
      ta = a && (awready === 1'b1);
      tw = w && (wready === 1'b1);
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        a = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    check(bresp, er);
    // Ready stays high between transfers
    @(posedge aclk);
  endtask

  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp,
                        input logic [1:0] er);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    check(rdata, {24'h0, exp});
    check(rresp, er);
    @(posedge aclk);
  endtask

  // Edges from input change to a change of the pin output
  task automatic lat(input logic v, output int n);
    logic prev;
    prev = p21_out;
    cmp_analog_out <= v;
    n = 0;
    do begin
      @(posedge aclk);
      @(negedge aclk);
      n++;
    end while (p21_out === prev && n < 40);
    @(posedge aclk);
  endtask

  task automatic test_reset_map();
    logic [7:0] idx [8] = '{IDX_DAC_ROUTE, IDX_FLAGS, IDX_DAC_CTL,
      IDX_CMP_CTL, IDX_INPUT_SEL, IDX_AMP_CTL, IDX_ENABLES, IDX_BG_SEL};
    logic [7:0] rst [8] = '{8'h01, 8'h00, 8'h00, 8'hc0, 8'hf7, 8'hec,
      8'h00, 8'hf8};
    for (int i = 0; i < 8; i++) chk_rd(idx[i], rst[i], RESP_OKAY);
    chk_rd(8'h10, 8'h00, RESP_SLVERR);
    axi_write(8'h10, 8'hff, RESP_SLVERR);
    check(p21_oe_n, 1'b1);
  endtask

  task automatic test_settle();
    int n;
    for (int d = 0; d < 4; d++) begin
      axi_write(IDX_CMP_CTL, 8'h20 | 8'(d), RESP_OKAY);
      repeat (40) @(posedge aclk);
      lat(1'b1, n);
      check(n, 3 + (d == 0 ? 1 : 2 << d));
      lat(1'b0, n);
      check(n, 3 + (d == 0 ? 1 : 2 << d));
    end
    // Short pulse then a gap must restart the 16-clock count
    cmp_analog_out <= 1'b1;
    repeat (10) @(posedge aclk);
    cmp_analog_out <= 1'b0;
    repeat (2) @(posedge aclk);
    lat(1'b1, n);
    check(n, 19);
    chk_rd(IDX_CMP_CTL, 8'h63, RESP_OKAY);
    lat(1'b0, n);
    chk_rd(IDX_CMP_CTL, 8'h23, RESP_OKAY);
    check(p21_oe_n, 1'b0);
    axi_write(IDX_CMP_CTL, 8'h10, RESP_OKAY);
    repeat (10) @(posedge aclk);
    check(p21_out, 1'b1);
    axi_write(IDX_CMP_CTL, 8'h80, RESP_OKAY);
    chk_rd(IDX_CMP_CTL, 8'hc0, RESP_OKAY);
  endtask

  task automatic test_trigger();
    for (int m = 0; m < 4; m++) begin
      axi_write(IDX_CMP_CTL, 8'(m << CC_TRIG_LO), RESP_OKAY);
      repeat (10) @(posedge aclk);
      axi_write(IDX_FLAGS, 8'hbf, RESP_OKAY);
      chk_rd(IDX_FLAGS, 8'h00, RESP_OKAY);
      cmp_analog_out <= 1'b1;
      repeat (10) @(posedge aclk);
      chk_rd(IDX_FLAGS, m != TRIG_FALL ? 8'h40 : 8'h00, RESP_OKAY);
      axi_write(IDX_FLAGS, 8'hbf, RESP_OKAY);
      // Service entry must not beat a standing high level
      isr_enter <= 1'b1;
      @(posedge aclk);
      isr_enter <= 1'b0;
      chk_rd(IDX_FLAGS, m == TRIG_HIGH ? 8'h40 : 8'h00, RESP_OKAY);
      cmp_analog_out <= 1'b0;
      repeat (10) @(posedge aclk);
      chk_rd(IDX_FLAGS, m != TRIG_RISE ? 8'h40 : 8'h00, RESP_OKAY);
    end
  endtask

  task automatic test_irq();
    axi_write(IDX_CMP_CTL, 8'h00, RESP_OKAY);
    cmp_analog_out <= 1'b1;
    repeat (10) @(posedge aclk);
    check(cmp_irq, 1'b0);
    axi_write(IDX_ENABLES, 8'h40, RESP_OKAY);
    check(cmp_irq, 1'b1);
    isr_enter <= 1'b1;
    @(posedge aclk);
    isr_enter <= 1'b0;
    @(negedge aclk);
    check(cmp_irq, 1'b0);
    @(posedge aclk);
    cmp_analog_out <= 1'b0;
    repeat (10) @(posedge aclk);
    cmp_analog_out <= 1'b1;
    other_flag_set <= 8'hff;
    @(posedge aclk);
    other_flag_set <= 8'h00;
    repeat (10) @(posedge aclk);
    chk_rd(IDX_FLAGS, 8'hf7, RESP_OKAY);
    axi_write(IDX_FLAGS, 8'hbf, RESP_OKAY);
    chk_rd(IDX_FLAGS, 8'hb7, RESP_OKAY);
    axi_write(IDX_FLAGS, 8'h00, RESP_OKAY);
    chk_rd(IDX_FLAGS, 8'h00, RESP_OKAY);
  endtask

  task automatic test_route();
    logic [3:0] p;
    axi_write(IDX_DAC_ROUTE, 8'h0e, RESP_OKAY);
    chk_rd(IDX_DAC_ROUTE, 8'h0e, RESP_OKAY);
    check({p34_amp_route, p20_dac_route, dac_buffer_select, dac_powerdown,
      cmp_powerdown}, 5'h1c);
    axi_write(IDX_DAC_ROUTE, 8'h01, RESP_OKAY);
    check({p34_amp_route, p20_dac_route, dac_buffer_select,
      dac_powerdown}, 4'h1);
    axi_write(IDX_DAC_CTL, 8'hfd, RESP_OKAY);
    axi_write(IDX_BG_SEL, 8'hf9, RESP_OKAY);
    check({dac_ref_bandgap, dac_level_code, bandgap_level_select},
      10'h3f5);
    for (int c = 0; c < 8; c++) begin
      p = c[2] ? 4'h0 : 4'h1 << c[1:0];
      axi_write(IDX_INPUT_SEL, {1'b0, c[2:0], 1'b1, c[2:0]}, RESP_OKAY);
      check({neg_uses_dac, neg_pin_connect, pos_uses_amp,
        pos_pin_connect}, {1'b0, p, 1'b0, p});
      axi_write(IDX_INPUT_SEL, {1'b1, c[2:0], 1'b0, c[2:0]}, RESP_OKAY);
      check({neg_uses_dac, neg_pin_connect, pos_uses_amp,
        pos_pin_connect}, 10'h210);
    end
    axi_write(IDX_AMP_CTL, 8'h5b, RESP_OKAY);
    check({amp_powerdown, amp_positive_source_select,
      amp_negative_level_select, amp_gain_select, amp_mode_select},
      8'h5b);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    cmp_analog_out = 1'b0;
    isr_enter = 1'b0;
    other_flag_set = 8'h00;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset_map();
    test_settle();
    test_trigger();
    test_irq();
    test_route();
    final_report();
  end
endmodule
